// ===== hw/rail_voltage_pg_delay_regs.sv
// Rail voltage, controller mode and power-good delay register bank
`timescale 1ns/1ns
module rail_voltage_pg_delay_regs #(
   parameter int MS_CYCLES = rail_regs_pkg::MS_CYCLES
) (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   output logic      [6:0] o_conv5_normal_code,
   output logic            o_conv5_passive_fall,
   output logic      [6:0] o_conv5_sleep_code,
   output logic      [6:0] o_conv6_normal_code,
   output logic            o_conv6_passive_fall,
   output logic      [6:0] o_conv6_sleep_code,
   output logic      [3:0] o_lowdrop2_sleep_code,
   output logic      [3:0] o_lowdrop2_normal_code,
   output logic      [3:0] o_lowdrop3_sleep_code,
   output logic      [3:0] o_lowdrop3_normal_code,
   output logic      [2:0] o_ctrl_pwm_force,
   output logic      [2:0] o_ctrl_kill_n,
   input  wire logic [2:0] i_ctrl_bus_force_on,
   input  wire logic [2:0] i_control_input_pins,
   output logic      [2:0] o_ctrl_run,
   input  wire logic [2:0] i_rails_in_range,
   input  wire logic [2:0] i_pin_good_mode,
   output logic            o_status_out_one,
   output logic            o_status_out_two,
   output logic            o_status_out_four
);
   logic [7:0] conv5_voltage_reg;
   logic [6:0] conv5_sleep_code_reg;
   logic [7:0] conv6_voltage_reg;
   logic [6:0] conv6_sleep_code_reg;
   logic [7:0] lowdrop2_voltages_reg;
   logic [7:0] lowdrop3_voltages_reg;
   logic [7:0] controllers_mode_kill_reg;
   logic [7:0] power_good_delays_reg;
   logic [7:0] rdata_next;
   logic [2:0] req_meta_reg;
   logic [2:0] req_sync_reg;
   logic [2:0] rails_meta_reg;
   logic [2:0] rails_sync_reg;
   logic [2:0] mode_meta_reg;
   logic [2:0] mode_sync_reg;
   logic [2:0] run_reg;

   // Write strobes per register
   wire logic wr_c5  = i_reg_wr && (i_reg_addr == rail_regs_pkg::CONV5_VOLTAGE_ADDR);
   wire logic wr_c5s = i_reg_wr && (i_reg_addr == rail_regs_pkg::CONV5_SLEEP_VOLTAGE_ADDR);
   wire logic wr_c6  = i_reg_wr && (i_reg_addr == rail_regs_pkg::CONV6_VOLTAGE_ADDR);
   wire logic wr_c6s = i_reg_wr && (i_reg_addr == rail_regs_pkg::CONV6_SLEEP_VOLTAGE_ADDR);
   wire logic wr_l2  = i_reg_wr && (i_reg_addr == rail_regs_pkg::LOWDROP2_VOLTAGES_ADDR);
   wire logic wr_l3  = i_reg_wr && (i_reg_addr == rail_regs_pkg::LOWDROP3_VOLTAGES_ADDR);
   wire logic wr_ck  = i_reg_wr && (i_reg_addr == rail_regs_pkg::CTRL_MODE_KILL_ADDR);
   wire logic wr_pg  = i_reg_wr && (i_reg_addr == rail_regs_pkg::POWER_GOOD_DELAYS_ADDR);

   // Sleep code field of a write
   wire logic [6:0] wr_code = i_reg_wdata[rail_regs_pkg::CODE_MSB:rail_regs_pkg::CODE_LSB];

   // Register storage
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         conv5_voltage_reg         <= rail_regs_pkg::CONV5_VOLTAGE_RST;
         conv5_sleep_code_reg      <= rail_regs_pkg::CONV5_SLEEP_CODE_RST;
         conv6_voltage_reg         <= rail_regs_pkg::CONV6_VOLTAGE_RST;
         conv6_sleep_code_reg      <= rail_regs_pkg::CONV6_SLEEP_CODE_RST;
         lowdrop2_voltages_reg     <= rail_regs_pkg::LOWDROP2_VOLTAGES_RST;
         lowdrop3_voltages_reg     <= rail_regs_pkg::LOWDROP3_VOLTAGES_RST;
         controllers_mode_kill_reg <= rail_regs_pkg::CTRL_MODE_KILL_RST;
         power_good_delays_reg     <= rail_regs_pkg::POWER_GOOD_DELAYS_RST;
      end else begin
         if (wr_c5) conv5_voltage_reg <= i_reg_wdata;
         if (wr_c5s) conv5_sleep_code_reg <= wr_code;
         if (wr_c6) conv6_voltage_reg <= i_reg_wdata;
         if (wr_c6s) conv6_sleep_code_reg <= wr_code;
         if (wr_l2) lowdrop2_voltages_reg <= i_reg_wdata;
         if (wr_l3) lowdrop3_voltages_reg <= i_reg_wdata;
         if (wr_ck) controllers_mode_kill_reg <= i_reg_wdata;
         if (wr_pg) power_good_delays_reg <= i_reg_wdata;
      end
   end

   // Read decode
   always_comb begin
      if (i_reg_addr == rail_regs_pkg::CONV5_VOLTAGE_ADDR) begin
         rdata_next = conv5_voltage_reg;
      end else if (i_reg_addr == rail_regs_pkg::CONV5_SLEEP_VOLTAGE_ADDR) begin
         rdata_next = {conv5_sleep_code_reg, rail_regs_pkg::RESERVED_BIT};
      end else if (i_reg_addr == rail_regs_pkg::CONV6_VOLTAGE_ADDR) begin
         rdata_next = conv6_voltage_reg;
      end else if (i_reg_addr == rail_regs_pkg::CONV6_SLEEP_VOLTAGE_ADDR) begin
         rdata_next = {conv6_sleep_code_reg, rail_regs_pkg::RESERVED_BIT};
      end else if (i_reg_addr == rail_regs_pkg::LOWDROP2_VOLTAGES_ADDR) begin
         rdata_next = lowdrop2_voltages_reg;
      end else if (i_reg_addr == rail_regs_pkg::LOWDROP3_VOLTAGES_ADDR) begin
         rdata_next = lowdrop3_voltages_reg;
      end else if (i_reg_addr == rail_regs_pkg::CTRL_MODE_KILL_ADDR) begin
         rdata_next = controllers_mode_kill_reg;
      end else if (i_reg_addr == rail_regs_pkg::POWER_GOOD_DELAYS_ADDR) begin
         rdata_next = power_good_delays_reg;
      end else begin
         rdata_next = rail_regs_pkg::UNMAPPED_READ;
      end
   end

   // Pin synchronisers, read data and controller run state
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         req_meta_reg   <= '0;
         req_sync_reg   <= '0;
         rails_meta_reg <= '0;
         rails_sync_reg <= '0;
         mode_meta_reg  <= '0;
         mode_sync_reg  <= '0;
         run_reg        <= '0;
         o_reg_rdata    <= rail_regs_pkg::UNMAPPED_READ;
      end else begin
         req_meta_reg   <= i_control_input_pins;
         req_sync_reg   <= req_meta_reg;
         rails_meta_reg <= i_rails_in_range;
         rails_sync_reg <= rails_meta_reg;
         mode_meta_reg  <= i_pin_good_mode;
         mode_sync_reg  <= mode_meta_reg;
         run_reg        <= o_ctrl_kill_n & (i_ctrl_bus_force_on | req_sync_reg);
         o_reg_rdata    <= rdata_next;
      end
   end

   // Field outputs to the regulators
   assign o_conv5_normal_code  = conv5_voltage_reg[rail_regs_pkg::CODE_MSB:rail_regs_pkg::CODE_LSB];
   assign o_conv5_passive_fall = conv5_voltage_reg[rail_regs_pkg::DECAY_BIT];
   assign o_conv5_sleep_code   = conv5_sleep_code_reg;
   assign o_conv6_normal_code  = conv6_voltage_reg[rail_regs_pkg::CODE_MSB:rail_regs_pkg::CODE_LSB];
   assign o_conv6_passive_fall = conv6_voltage_reg[rail_regs_pkg::DECAY_BIT];
   assign o_conv6_sleep_code   = conv6_sleep_code_reg;
   assign o_lowdrop2_sleep_code =
      lowdrop2_voltages_reg[rail_regs_pkg::NIB_HI_MSB:rail_regs_pkg::NIB_HI_LSB];
   assign o_lowdrop2_normal_code =
      lowdrop2_voltages_reg[rail_regs_pkg::NIB_LO_MSB:rail_regs_pkg::NIB_LO_LSB];
   assign o_lowdrop3_sleep_code =
      lowdrop3_voltages_reg[rail_regs_pkg::NIB_HI_MSB:rail_regs_pkg::NIB_HI_LSB];
   assign o_lowdrop3_normal_code =
      lowdrop3_voltages_reg[rail_regs_pkg::NIB_LO_MSB:rail_regs_pkg::NIB_LO_LSB];
   assign o_ctrl_pwm_force =
      controllers_mode_kill_reg[rail_regs_pkg::MODE_MSB:rail_regs_pkg::MODE_LSB];
   assign o_ctrl_kill_n =
      controllers_mode_kill_reg[rail_regs_pkg::KILL_MSB:rail_regs_pkg::KILL_LSB];
   assign o_ctrl_run = run_reg;

   // Delay codes: index 0 out one, 1 out two, 2 out four
   wire logic [2:0] dly_code [3];
   assign dly_code[0] = {1'b0,
      power_good_delays_reg[rail_regs_pkg::OUT1_DLY_MSB:rail_regs_pkg::OUT1_DLY_LSB]};
   assign dly_code[1] =
      power_good_delays_reg[rail_regs_pkg::OUT2_DLY_MSB:rail_regs_pkg::OUT2_DLY_LSB];
   assign dly_code[2] =
      power_good_delays_reg[rail_regs_pkg::OUT4_DLY_MSB:rail_regs_pkg::OUT4_DLY_LSB];

   pg_timer_if pg_if [3] ();
   wire logic [2:0] good;

   // One delay timer per status output
   for (genvar g = 0; g < 3; g++) begin : g_pg
      assign pg_if[g].rails_ok   = rails_sync_reg[g];
      assign pg_if[g].enable     = mode_sync_reg[g];
      assign pg_if[g].delay_code = dly_code[g];
      assign good[g]             = pg_if[g].good;
      pg_delay_timer #(
         .MS_CYCLES (MS_CYCLES)
      ) u_timer (
         .i_clk  (i_clk),
         .i_nrst (i_nrst),
         .port   (pg_if[g].timer)
      );
   end

   assign o_status_out_one  = good[0];
   assign o_status_out_two  = good[1];
   assign o_status_out_four = good[2];

   // Checks on the register bank and timers
   conv5_write_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_c5 |=> o_conv5_normal_code == $past(i_reg_wdata[7:1]))
      else $error("conv5 normal code not written");
   decay_follow_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_c6 |=> o_conv6_passive_fall == $past(i_reg_wdata[0]))
      else $error("conv6 decay bit not written");
   sleep_reserved_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_reg_addr == rail_regs_pkg::CONV5_SLEEP_VOLTAGE_ADDR ||
       i_reg_addr == rail_regs_pkg::CONV6_SLEEP_VOLTAGE_ADDR)
      |=> o_reg_rdata[rail_regs_pkg::DECAY_BIT] == rail_regs_pkg::RESERVED_BIT)
      else $error("reserved sleep bit read non-zero");
   lowdrop_split_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_l2 |=> {o_lowdrop2_sleep_code, o_lowdrop2_normal_code} == $past(i_reg_wdata))
      else $error("lowdrop2 nibbles wrong");
   kill_off_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !o_ctrl_kill_n[0] |=> !o_ctrl_run[0])
      else $error("killed controller still runs");
   force_on_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (o_ctrl_kill_n[1] && i_ctrl_bus_force_on[1]) |=> o_ctrl_run[1])
      else $error("forced controller not running");
   rail_loss_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !rails_sync_reg[1] |=> !o_status_out_two)
      else $error("status held through rail loss");
   zero_delay_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      ($rose(rails_sync_reg[2]) && dly_code[2] == 3'h0 && mode_sync_reg[2])
         ##1 (rails_sync_reg[2] && dly_code[2] == 3'h0 && mode_sync_reg[2])
         |=> o_status_out_four)
      else $error("zero delay output late");
   gpo_mode_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !mode_sync_reg[0] |=> !o_status_out_one)
      else $error("status asserted outside good mode");
   unmapped_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_reg_addr < rail_regs_pkg::CONV5_VOLTAGE_ADDR ||
       i_reg_addr > rail_regs_pkg::POWER_GOOD_DELAYS_ADDR)
      |=> o_reg_rdata == rail_regs_pkg::UNMAPPED_READ)
      else $error("unmapped read non-zero");

   // Field write checks
   conv5_sleep_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_c5s |=> o_conv5_sleep_code == $past(wr_code))
      else $error("conv5 sleep code not written");
   conv6_normal_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_c6 |=> o_conv6_normal_code == $past(wr_code))
      else $error("conv6 normal code not written");
   conv6_sleep_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_c6s |=> o_conv6_sleep_code == $past(wr_code))
      else $error("conv6 sleep code not written");
   lowdrop3_split_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_l3 |=> {o_lowdrop3_sleep_code, o_lowdrop3_normal_code} == $past(i_reg_wdata))
      else $error("lowdrop3 nibbles wrong");
   mode_bits_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_ck |=> o_ctrl_pwm_force ==
         $past(i_reg_wdata[rail_regs_pkg::MODE_MSB:rail_regs_pkg::MODE_LSB]))
      else $error("controller mode bits not written");
   spare_read_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_ck ##1 (i_reg_addr == rail_regs_pkg::CTRL_MODE_KILL_ADDR)
      |=> o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("controller register read back wrong");
   out2_code_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_pg |=> dly_code[1] ==
         $past(i_reg_wdata[rail_regs_pkg::OUT2_DLY_MSB:rail_regs_pkg::OUT2_DLY_LSB]))
      else $error("out two delay code wrong");
   out4_code_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_pg |=> dly_code[2] ==
         $past(i_reg_wdata[rail_regs_pkg::OUT4_DLY_MSB:rail_regs_pkg::OUT4_DLY_LSB]))
      else $error("out four delay code wrong");
   out1_code_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      wr_pg |=> dly_code[0] ==
         {1'b0, $past(i_reg_wdata[rail_regs_pkg::OUT1_DLY_MSB:rail_regs_pkg::OUT1_DLY_LSB])})
      else $error("out one delay code wrong");
endmodule : rail_voltage_pg_delay_regs

// ===== include/rail_regs_pkg.sv
// Register map, field layout and timing constants for the rail register bank
package rail_regs_pkg;
   // Register byte addresses
   localparam logic [7:0] CONV5_VOLTAGE_ADDR       = 8'h96;
   localparam logic [7:0] CONV5_SLEEP_VOLTAGE_ADDR = 8'h97;
   localparam logic [7:0] CONV6_VOLTAGE_ADDR       = 8'h98;
   localparam logic [7:0] CONV6_SLEEP_VOLTAGE_ADDR = 8'h99;
   localparam logic [7:0] LOWDROP2_VOLTAGES_ADDR   = 8'h9a;
   localparam logic [7:0] LOWDROP3_VOLTAGES_ADDR   = 8'h9b;
   localparam logic [7:0] CTRL_MODE_KILL_ADDR      = 8'h9c;
   localparam logic [7:0] POWER_GOOD_DELAYS_ADDR   = 8'h9d;
   // Reset values
   localparam logic [7:0] CONV5_VOLTAGE_RST        = 8'h70;
   localparam logic [6:0] CONV5_SLEEP_CODE_RST     = 7'h74;
   localparam logic [7:0] CONV6_VOLTAGE_RST        = 8'he8;
   localparam logic [6:0] CONV6_SLEEP_CODE_RST     = 7'h74;
   localparam logic [7:0] LOWDROP2_VOLTAGES_RST    = 8'hff;
   localparam logic [7:0] LOWDROP3_VOLTAGES_RST    = 8'haa;
   localparam logic [7:0] CTRL_MODE_KILL_RST       = 8'h07;
   localparam logic [7:0] POWER_GOOD_DELAYS_RST    = 8'h21;
   localparam logic [7:0] UNMAPPED_READ            = 8'h00;
   localparam logic       RESERVED_BIT             = 1'b0;
   // Field positions
   localparam int CODE_MSB  = 7;
   localparam int CODE_LSB  = 1;
   localparam int DECAY_BIT = 0;
   localparam int NIB_HI_MSB = 7;
   localparam int NIB_HI_LSB = 4;
   localparam int NIB_LO_MSB = 3;
   localparam int NIB_LO_LSB = 0;
   localparam int MODE_MSB  = 5;
   localparam int MODE_LSB  = 3;
   localparam int KILL_MSB  = 2;
   localparam int KILL_LSB  = 0;
   localparam int OUT2_DLY_MSB = 7;
   localparam int OUT2_DLY_LSB = 5;
   localparam int OUT4_DLY_MSB = 4;
   localparam int OUT4_DLY_LSB = 2;
   localparam int OUT1_DLY_MSB = 1;
   localparam int OUT1_DLY_LSB = 0;
   // Timing: one millisecond in clock cycles, rounded down
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS         = 1_000_000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   // Delay code to milliseconds
   typedef logic [6:0] ms_t;
   localparam ms_t DELAY_MS [0:7] = '{7'h00, 7'h05, 7'h0a, 7'h0f,
                                      7'h14, 7'h32, 7'h4b, 7'h64};
endpackage : rail_regs_pkg

// ===== include/pg_timer_if.sv
// Carrier between the register bank and one power-good delay timer
`timescale 1ns/1ns
interface pg_timer_if;
   logic       rails_ok;
   logic       enable;
   logic [2:0] delay_code;
   logic       good;
   modport owner (output rails_ok, output enable, output delay_code, input good);
   modport timer (input rails_ok, input enable, input delay_code, output good);
endinterface : pg_timer_if

// ===== hw/pg_delay_timer.sv
// Power-good delay timer for one status output
`timescale 1ns/1ns
module pg_delay_timer #(
   parameter int MS_CYCLES = rail_regs_pkg::MS_CYCLES
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   pg_timer_if.timer port
);
   localparam int PW = $clog2(MS_CYCLES + 1);
   typedef enum logic [1:0] {WAIT_RAILS, COUNTING, GOOD} pg_state_t;

   pg_state_t          state_reg;
   pg_state_t          state_next;
   logic [PW-1:0]      pre_reg;
   logic [PW-1:0]      pre_next;
   rail_regs_pkg::ms_t ms_reg;
   rail_regs_pkg::ms_t ms_next;

   wire rail_regs_pkg::ms_t target = rail_regs_pkg::DELAY_MS[port.delay_code];
   wire logic               tick   = (pre_reg == PW'(MS_CYCLES - 1));
   wire logic               armed  = port.rails_ok && port.enable;

   // Next state of the delay count
   always_comb begin
      state_next = state_reg;
      pre_next   = pre_reg;
      ms_next    = ms_reg;
      case (state_reg)
         WAIT_RAILS: begin
            pre_next = '0;
            ms_next  = '0;
            if (armed) begin
               state_next = COUNTING;
            end
         end
         COUNTING: begin
            if (ms_reg >= target) begin
               state_next = GOOD;
            end else begin
               pre_next = tick ? '0 : PW'(pre_reg + 1'b1);
               if (tick) begin
                  ms_next = rail_regs_pkg::ms_t'(ms_reg + 1'b1);
               end
            end
         end
         default: begin
            state_next = GOOD;
         end
      endcase
      if (!armed) begin
         state_next = WAIT_RAILS;
         pre_next   = '0;
         ms_next    = '0;
      end
   end

   // State registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= WAIT_RAILS;
         pre_reg   <= '0;
         ms_reg    <= '0;
      end else begin
         state_reg <= state_next;
         pre_reg   <= pre_next;
         ms_reg    <= ms_next;
      end
   end

   assign port.good = (state_reg == GOOD);
endmodule : pg_delay_timer

// ===== sim/rail_voltage_pg_delay_regs_tb_top.sv
// Self-checking bench for the rail register bank
`timescale 1ns/1ns
module rail_voltage_pg_delay_regs_tb_top;
   localparam int MS = 4;
   logic       i_clk, i_nrst, i_reg_wr;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic [6:0] o_conv5_normal_code, o_conv5_sleep_code, o_conv6_normal_code, o_conv6_sleep_code;
   logic       o_conv5_passive_fall, o_conv6_passive_fall;
   logic [3:0] o_lowdrop2_sleep_code, o_lowdrop2_normal_code;
   logic [3:0] o_lowdrop3_sleep_code, o_lowdrop3_normal_code;
   logic [2:0] o_ctrl_pwm_force, o_ctrl_kill_n, i_ctrl_bus_force_on, i_control_input_pins;
   logic [2:0] o_ctrl_run, i_rails_in_range, i_pin_good_mode;
   logic       o_status_out_one, o_status_out_two, o_status_out_four;
   wire  [2:0] st = {o_status_out_four, o_status_out_two, o_status_out_one};
   int         errors, checked;
   logic       rd_tag, rd_seen;
   logic [7:0] exp_q [$];
   logic [7:0] val [8] = '{8'h70, 8'he8, 8'he8, 8'he8, 8'hff, 8'haa, 8'h07, 8'h21};
   int         ms_tab [8] = '{0, 5, 10, 15, 20, 50, 75, 100};

   rail_voltage_pg_delay_regs #(.MS_CYCLES(MS)) dut (
      .i_clk, .i_nrst, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
      .o_conv5_normal_code, .o_conv5_passive_fall, .o_conv5_sleep_code,
      .o_conv6_normal_code, .o_conv6_passive_fall, .o_conv6_sleep_code,
      .o_lowdrop2_sleep_code, .o_lowdrop2_normal_code, .o_lowdrop3_sleep_code,
      .o_lowdrop3_normal_code, .o_ctrl_pwm_force, .o_ctrl_kill_n, .i_ctrl_bus_force_on,
      .i_control_input_pins, .o_ctrl_run, .i_rails_in_range, .i_pin_good_mode,
      .o_status_out_one, .o_status_out_two, .o_status_out_four);

   // Free-running 25 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmp_rd

   task automatic cmp_out(input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmp_out

   task automatic summarize();
      $display("compares %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // Expected read data; reserved bits and unmapped places read zero
   function automatic logic [7:0] expv(input logic [7:0] a);
      if (a < 8'h96 || a > 8'h9d) return 8'h00;
      if (a == 8'h97 || a == 8'h99) return val[3'(a - 8'h96)] & 8'hfe;
      return val[3'(a - 8'h96)];
   endfunction : expv

   // Write strobe stays high so calls in a row are back to back
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      if (a >= 8'h96 && a <= 8'h9d) val[3'(a - 8'h96)] = d;
   endtask : wr

   // Read note goes to the queue, the monitor checks the answer
   task automatic rd(input logic [7:0] a);
      @(negedge i_clk);
      i_reg_wr = 1'b0;
      i_reg_addr = a;
      rd_tag = 1'b1;
      exp_q.push_back(expv(a));
      @(negedge i_clk);
      rd_tag = 1'b0;
   endtask : rd

   // Read data monitor
   always @(posedge i_clk) rd_seen <= rd_tag;
   always @(negedge i_clk) begin
      if (rd_seen && exp_q.size() > 0) cmp_rd(exp_q.pop_front(), o_reg_rdata);
   end

   // Field outputs against the register image
   task automatic chk_fields();
      cmp_out(16'(val[0][7:1]), 16'(o_conv5_normal_code));
      cmp_out(16'(val[0][0]), 16'(o_conv5_passive_fall));
      cmp_out(16'(val[1][7:1]), 16'(o_conv5_sleep_code));
      cmp_out(16'(val[2][7:1]), 16'(o_conv6_normal_code));
      cmp_out(16'(val[2][0]), 16'(o_conv6_passive_fall));
      cmp_out(16'(val[3][7:1]), 16'(o_conv6_sleep_code));
      cmp_out(16'(val[4]), 16'({o_lowdrop2_sleep_code, o_lowdrop2_normal_code}));
      cmp_out(16'(val[5]), 16'({o_lowdrop3_sleep_code, o_lowdrop3_normal_code}));
      cmp_out(16'(val[6][5:3]), 16'(o_ctrl_pwm_force));
      cmp_out(16'(val[6][2:0]), 16'(o_ctrl_kill_n));
   endtask : chk_fields

   // Time from rails in range to status high, then drop
   task automatic pg_meas(input int idx, input int ms);
      int n;
      int e;
      n = 0;
      e = 4 + ms * MS;
      @(negedge i_clk);
      i_reg_wr = 1'b0;
      i_rails_in_range[idx] = 1'b1;
      do begin
         @(negedge i_clk);
         n++;
      end while (n < 600 && st[idx] !== 1'b1);
      if (n >= e - ms * MS / 10 && n <= e + ms * MS / 10) n = e;
      cmp_out(16'(e), 16'(n));
      i_rails_in_range[idx] = 1'b0;
      repeat (4) @(negedge i_clk);
      cmp_out(16'h0000, 16'(st[idx]));
   endtask : pg_meas

   initial begin
      logic [2:0] f;
      logic [2:0] p;
      i_nrst = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_addr = 8'h00;
      i_reg_wdata = 8'h00;
      rd_tag = 1'b0;
      rd_seen = 1'b0;
      i_ctrl_bus_force_on = 3'b000;
      i_control_input_pins = 3'b000;
      i_rails_in_range = 3'b000;
      i_pin_good_mode = 3'b111;
      void'($urandom(32'h7826_2131));
      repeat (20) @(negedge i_clk);
      i_nrst = 1'b1;
      chk_fields();
      for (int a = 8'h94; a <= 8'h9f; a++) rd(8'(a));
      $display("test reset values done");
      for (int k = 0; k < 8; k++) wr(8'(8'h96 + k), 8'($urandom) | 8'h01);
      wr(8'h9e, 8'hff);
      wr(8'h95, 8'hff);
      for (int a = 8'h94; a <= 8'h9f; a++) rd(8'(a));
      chk_fields();
      $display("test register writes done");
      // controller run from kill, force and pins
      for (int k = 0; k < 8; k++) begin
         wr(8'h9c, 8'($urandom));
         f = 3'($urandom);
         p = 3'($urandom);
         @(negedge i_clk);
         i_reg_wr = 1'b0;
         i_ctrl_bus_force_on = f;
         i_control_input_pins = p;
         repeat (4) @(negedge i_clk);
         cmp_out(16'(val[6][2:0] & (f | p)), 16'(o_ctrl_run));
      end
      rd(8'h9c);
      $display("test controller run done");
      // every delay code on every output
      for (int c = 0; c < 8; c++) begin
         wr(8'h9d, {3'(c), 3'(c), 2'(c)});
         pg_meas(1, ms_tab[c]);
         pg_meas(2, ms_tab[c]);
         pg_meas(0, ms_tab[c % 4]);
      end
      $display("test delay codes done");
      // rail loss mid-count restarts the delay
      wr(8'h9d, 8'h60);
      @(negedge i_clk);
      i_reg_wr = 1'b0;
      i_rails_in_range[1] = 1'b1;
      repeat (40) @(negedge i_clk);
      cmp_out(16'h0000, 16'(st[1]));
      i_rails_in_range[1] = 1'b0;
      repeat (4) @(negedge i_clk);
      pg_meas(1, 15);
      // status held low when pin not in power-good mode
      i_pin_good_mode = 3'b011;
      i_rails_in_range[2] = 1'b1;
      repeat (30) @(negedge i_clk);
      cmp_out(16'h0000, 16'(st[2]));
      i_rails_in_range[2] = 1'b0;
      i_pin_good_mode = 3'b111;
      $display("test restart and mode done");
      repeat (4) @(negedge i_clk);
      summarize();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge i_clk);
      errors++;
      summarize();
   end
endmodule : rail_voltage_pg_delay_regs_tb_top
